// ==== rtl/nand_host_pkg.sv ====
// Purpose: shared constants, types and helpers for the stacked-die nand host controller
// Assumes: 100 MHz clock; 29-bit byte address, 2 KiB pages, 64 pages per block
// Notes: all bus timings are least times, rounded up to whole cycles
package nand_host_pkg;

    localparam int CLK_MHZ = 100;                 // clock rate

    // least times, in their own units
    localparam int T_INIT_US  = 20;               // power-on initialisation
    localparam int T_SLEEP_US = 10;               // select-high idle before sleep
    localparam int T_WAKE_NS  = 100;              // select_wake_delay
    localparam int T_WB_NS    = 100;              // command to busy indication
    localparam int T_SETUP_NS = 10;               // latch and data setup
    localparam int T_WP_NS    = 20;               // write strobe low
    localparam int T_RP_NS    = 60;               // read strobe low, covers sync latency
    localparam int T_HOLD_NS  = 20;               // strobe high hold

    typedef logic [11:0] cnt_t;                   // cycle counter

    // least time to cycles, rounded up, never below one
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : cyc_ceil

    localparam cnt_t INIT_CYC  = cnt_t'(cyc_ceil(T_INIT_US * 1000));
    localparam cnt_t SLEEP_CYC = cnt_t'(cyc_ceil(T_SLEEP_US * 1000));
    localparam cnt_t WAKE_CYC  = cnt_t'(cyc_ceil(T_WAKE_NS));
    localparam cnt_t WB_CYC    = cnt_t'(cyc_ceil(T_WB_NS));
    localparam cnt_t SETUP_CYC = cnt_t'(cyc_ceil(T_SETUP_NS));
    localparam cnt_t WP_CYC    = cnt_t'(cyc_ceil(T_WP_NS));
    localparam cnt_t RP_CYC    = cnt_t'(cyc_ceil(T_RP_NS));
    localparam cnt_t HOLD_CYC  = cnt_t'(cyc_ceil(T_HOLD_NS));

    // address layout
    localparam int ADDR_W    = 29;
    localparam int COL_HI    = 10;                // column bits 10..0
    localparam int PAGE_LSB  = 11;
    localparam int PAGE_W    = 6;
    localparam int BLOCK_LSB = 17;
    localparam int BLOCK_W   = 12;
    localparam int DIE_LSB   = 27;
    localparam int DIES      = 4;

    typedef logic [ADDR_W-1:0]  addr_t;
    typedef logic [PAGE_W-1:0]  page_t;
    typedef logic [BLOCK_W-1:0] block_t;
    typedef logic [1:0]         die_t;

    // die range thresholds
    localparam addr_t DIE0_MAX = 29'h07ffffff;
    localparam addr_t DIE1_MAX = 29'h0fffffff;
    localparam addr_t DIE2_MAX = 29'h17ffffff;

    localparam logic [7:0] CMD_STATUS_BASE  = 8'h72;
    localparam int         STATUS_READY_BIT = 6;

    typedef enum logic [2:0] {
        OP_CMD        = 3'h0,                     // one command byte
        OP_ADDR       = 3'h1,                     // five address cycles, unchecked
        OP_PROG_ADDR  = 3'h2,                     // five address cycles, page order checked
        OP_WR         = 3'h3,                     // one data byte out
        OP_RD         = 3'h4,                     // one data byte in
        OP_DIE_STATUS = 3'h5,                     // per-die status query
        OP_WAIT_READY = 3'h6                      // wait on ready/busy
    } op_e;

    typedef enum logic [1:0] {
        K_CMD  = 2'h0,
        K_ADDR = 2'h1,
        K_WR   = 2'h2,
        K_RD   = 2'h3
    } kind_e;

    typedef struct packed {
        op_e        op;
        addr_t      addr;
        logic [7:0] data;
    } req_s;

    typedef struct packed {
        logic [7:0] data;                         // byte read back
        logic       ready_bit;                    // status bit six
        logic       err;                          // refused request
    } rsp_s;

    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       wp_n;
        logic       io_oe;
        logic [7:0] io_out;
    } pins_s;

    typedef struct packed {
        kind_e      kind;
        logic [7:0] val;
    } step_s;

    // die by address thresholds, same as the two top bits
    function automatic die_t die_of(input addr_t a);
        if (a <= DIE0_MAX) return 2'h0;
        if (a <= DIE1_MAX) return 2'h1;
        if (a <= DIE2_MAX) return 2'h2;
        return 2'h3;
    endfunction : die_of

endpackage : nand_host_pkg

// ==== rtl/pin_sync.sv ====
// Purpose: three-stage synchroniser for the pins read back from the flash
// Assumes: inputs stay stable while sampled as a group
// Notes: output moves only when the second and third stages agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    if (WIDTH < 1) begin : bad_width
        $error("pin_sync needs at least one bit");
    end

    logic [WIDTH-1:0] s1_r;                       // metastable stage, read by s2 only
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // shift chain; reset to zero so ready/busy reads busy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q <= s3_r;                        // glitch filtered
            end
        end
    end
endmodule : pin_sync

// ==== rtl/nand_host.sv ====
// Purpose: host controller driving a stacked-die nand over its strobe pins
// Assumes: one flash package, shared ready/busy pin, 8-bit data bus
// Notes: one request at a time; responses pulse rsp_valid for one cycle
`timescale 1ns/1ps
module nand_host
    import nand_host_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       req_valid,
    input  wire req_s       req,
    output logic            req_ready,
    output logic            rsp_valid,
    output rsp_s            rsp,
    output logic            init_done,
    output pins_s           pins,
    input  wire logic       rb,
    input  wire logic [7:0] io_in
);
    typedef enum logic [7:0] {
        ST_INIT    = 8'h01,                       // power-on wait
        ST_INIT_RB = 8'h02,                       // wait for first ready
        ST_IDLE    = 8'h04,
        ST_WAKE    = 8'h08,                       // select held before first strobe
        ST_SETUP   = 8'h10,
        ST_LOW     = 8'h20,                       // strobe low
        ST_HIGH    = 8'h40,                       // strobe high
        ST_BUSY    = 8'h80                        // waiting on ready/busy
    } state_e;

    state_e      state_r;                         // main sequencer
    req_s        op_r;                            // request in flight
    logic [2:0]  step_r;                          // bus cycle index
    cnt_t        cnt_r;                           // phase down-counter
    pins_s       pins_r;                          // pin register
    rsp_s        rsp_r;
    logic        rsp_valid_r;
    logic        req_ready_r;
    logic        init_done_r;
    logic [7:0]  rd_data_r;                       // last byte read
    cnt_t        idle_cnt_r;                      // select-high time
    logic        asleep_r;                        // device may be sleeping
    block_t      last_blk_r [DIES];               // last programmed block per die
    page_t       last_pg_r  [DIES];
    logic        seen_r     [DIES];
    logic        rb_s;                            // synchronised ready/busy
    logic [7:0]  io_s;                            // synchronised data bus
    logic        req_fire;
    logic        order_ok;
    step_s       cur_step;
    die_t        req_die;
    block_t      req_blk;
    page_t       req_pg;

    pin_sync #(.WIDTH(9)) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .d      ({rb, io_in}),
        .q      ({rb_s, io_s})
    );

    // number of bus cycles an operation takes
    function automatic logic [2:0] steps_of(input op_e op);
        unique case (op)
            OP_ADDR, OP_PROG_ADDR: return 3'h5;
            OP_DIE_STATUS:         return 3'h2;
            OP_WAIT_READY:         return 3'h0;
            default:               return 3'h1;
        endcase
    endfunction : steps_of

    // kind and byte of one bus cycle
    function automatic step_s step_of(input req_s r, input logic [2:0] idx);
        step_s s;
        s.kind = K_CMD;
        s.val  = r.data;
        unique case (r.op)
            OP_CMD: s.kind = K_CMD;
            OP_WR:  s.kind = K_WR;
            OP_RD:  s.kind = K_RD;
            OP_DIE_STATUS: begin
                if (idx == 3'h0) begin
                    s.kind = K_CMD;
                    s.val  = CMD_STATUS_BASE + 8'(die_of(r.addr));
                end else begin
                    s.kind = K_RD;                // status byte follows directly
                end
            end
            default: begin
                s.kind = K_ADDR;                  // two column then three row cycles
                unique case (idx)
                    3'h0:    s.val = r.addr[7:0];
                    3'h1:    s.val = {5'h0, r.addr[COL_HI:8]};
                    3'h2:    s.val = r.addr[PAGE_LSB+7:PAGE_LSB];
                    3'h3:    s.val = r.addr[PAGE_LSB+15:PAGE_LSB+8];
                    default: s.val = {6'h0, r.addr[ADDR_W-1:DIE_LSB]};
                endcase
            end
        endcase
        return s;
    endfunction : step_of

    // pins set up for one bus cycle, strobes still high
    function automatic pins_s setup_pins(input pins_s p, input step_s s);
        pins_s n;
        n        = p;
        n.ce_n   = 1'b0;
        n.cle    = (s.kind == K_CMD);
        n.ale    = (s.kind == K_ADDR);
        n.io_oe  = (s.kind != K_RD);
        n.io_out = s.val;
        return n;
    endfunction : setup_pins

    assign req_fire = req_valid && req_ready_r;
    assign cur_step = step_of(op_r, step_r);
    assign req_die  = req.addr[ADDR_W-1:DIE_LSB];
    assign req_blk  = req.addr[BLOCK_LSB+BLOCK_W-1:BLOCK_LSB];
    assign req_pg   = req.addr[PAGE_LSB+PAGE_W-1:PAGE_LSB];

    // next page must follow the last one, a fresh block starts at page zero
    assign order_ok = (seen_r[req_die] && req_blk == last_blk_r[req_die])
                    ? (req_pg == page_t'(last_pg_r[req_die] + 1'b1))
                    : (req_pg == '0);

    // per-die program position; other dies keep their own
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DIES; i++) begin
                last_blk_r[i] <= '0;
                last_pg_r[i]  <= '0;
                seen_r[i]     <= 1'b0;
            end
        end else if (req_fire && req.op == OP_PROG_ADDR && order_ok) begin
            last_blk_r[req_die] <= req_blk;
            last_pg_r[req_die]  <= req_pg;
            seen_r[req_die]     <= 1'b1;
        end
    end

    // counter and flag each lag one cycle behind the pin the device watches
    localparam cnt_t SLEEP_LAG = cnt_t'(2);

    // select-high idle tracking; flag raised early so a wake is never missed
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_r <= '0;
            asleep_r   <= 1'b0;
        end else if (!pins_r.ce_n) begin
            idle_cnt_r <= '0;
            asleep_r   <= 1'b0;
        end else if (idle_cnt_r < SLEEP_CYC - SLEEP_LAG) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end else begin
            asleep_r   <= 1'b1;
        end
    end

    // main sequencer: init, then one request at a time
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_INIT;
            op_r        <= '0;
            step_r      <= '0;
            cnt_r       <= INIT_CYC;
            pins_r      <= '{ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, default: '0};
            rsp_r       <= '0;
            rsp_valid_r <= 1'b0;
            req_ready_r <= 1'b0;
            init_done_r <= 1'b0;
            rd_data_r   <= '0;
        end else begin
            rsp_valid_r <= 1'b0;
            unique case (state_r)
                ST_INIT: begin
                    // write guard held low from reset until ready
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else state_r <= ST_INIT_RB;
                end
                ST_INIT_RB: begin
                    if (rb_s) begin
                        // page zero now waits in cache for plain reads
                        pins_r.wp_n <= 1'b1;
                        init_done_r <= 1'b1;
                        req_ready_r <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // accepted even while another die is busy
                    if (req_fire) begin
                        req_ready_r <= 1'b0;
                        op_r        <= req;
                        step_r      <= '0;
                        if (req.op == OP_PROG_ADDR && !order_ok) begin
                            rsp_r       <= '{err: 1'b1, default: '0};
                            rsp_valid_r <= 1'b1;
                            req_ready_r <= 1'b1;
                        end else if (req.op == OP_WAIT_READY) begin
                            cnt_r   <= WB_CYC;
                            state_r <= ST_BUSY;
                        end else if (asleep_r) begin
                            pins_r.ce_n <= 1'b0;                 // wake first
                            cnt_r       <= WAKE_CYC;
                            state_r     <= ST_WAKE;
                        end else begin
                            pins_r  <= setup_pins(pins_r, step_of(req, 3'h0));
                            cnt_r   <= SETUP_CYC;
                            state_r <= ST_SETUP;
                        end
                    end
                end
                ST_WAKE: begin
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else begin
                        pins_r  <= setup_pins(pins_r, cur_step);
                        cnt_r   <= SETUP_CYC;
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else if (cur_step.kind == K_RD) begin
                        pins_r.re_n <= 1'b0;
                        cnt_r       <= RP_CYC;
                        state_r     <= ST_LOW;
                    end else begin
                        pins_r.we_n <= 1'b0;
                        cnt_r       <= WP_CYC;
                        state_r     <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else begin
                        if (cur_step.kind == K_RD) rd_data_r <= io_s;
                        pins_r.we_n <= 1'b1;
                        pins_r.re_n <= 1'b1;
                        cnt_r       <= HOLD_CYC;
                        state_r     <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else if (step_r + 3'h1 < steps_of(op_r.op)) begin
                        step_r  <= step_r + 3'h1;
                        pins_r  <= setup_pins(pins_r, step_of(op_r, step_r + 3'h1));
                        cnt_r   <= SETUP_CYC;
                        state_r <= ST_SETUP;
                    end else begin
                        // release select so the device may sleep
                        pins_r.ce_n  <= 1'b1;
                        pins_r.cle   <= 1'b0;
                        pins_r.ale   <= 1'b0;
                        pins_r.io_oe <= 1'b0;
                        rsp_r.data      <= rd_data_r;
                        rsp_r.ready_bit <= rd_data_r[STATUS_READY_BIT];
                        rsp_r.err       <= 1'b0;
                        rsp_valid_r <= 1'b1;
                        req_ready_r <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    // ignore the pin until busy can have shown
                    if (cnt_r > 1) cnt_r <= cnt_r - 1'b1;
                    else if (rb_s) begin
                        rsp_r       <= '{ready_bit: 1'b1, default: '0};
                        rsp_valid_r <= 1'b1;
                        req_ready_r <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign req_ready = req_ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp       = rsp_r;
    assign init_done = init_done_r;
    assign pins      = pins_r;

    // helpers for the wake check
    logic wake_hold_r;                            // select dropped out of sleep
    cnt_t since_fall_r;                           // cycles since select fell
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wake_hold_r  <= 1'b0;
            since_fall_r <= '0;
        end else begin
            if (state_r == ST_WAKE) wake_hold_r <= 1'b1;
            else if (pins_r.ce_n) wake_hold_r <= 1'b0;
            if (pins_r.ce_n) since_fall_r <= '0;
            else if (since_fall_r < SLEEP_CYC) since_fall_r <= since_fall_r + 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence status_cmd_s;
        state_r == ST_LOW && !pins_r.we_n && pins_r.cle && op_r.op == OP_DIE_STATUS;
    endsequence
    sequence status_read_s;
        !pins_r.re_n && !pins_r.cle && !pins_r.ale && !pins_r.io_oe;
    endsequence

    wp_guard_a: assert property (!init_done_r |-> !pins_r.wp_n)
        else $error("write guard released before init done");
    wake_delay_a: assert property (
        (wake_hold_r && (!pins_r.we_n || !pins_r.re_n)) |-> since_fall_r >= WAKE_CYC)
        else $error("strobe too soon after wake");
    status_opcode_a: assert property (status_cmd_s |->
        pins_r.io_out == CMD_STATUS_BASE + 8'(op_r.addr[ADDR_W-1:DIE_LSB]))
        else $error("wrong die status opcode");
    die_range_a: assert property ((status_cmd_s and (op_r.addr > DIE2_MAX)) |->
        pins_r.io_out == CMD_STATUS_BASE + 8'h03)
        else $error("top die range gives wrong opcode");
    status_read_a: assert property (status_cmd_s ##1 pins_r.we_n |->
        ##[1:20] status_read_s)
        else $error("status query not followed by read strobe");
    prog_order_a: assert property (
        (req_fire && req.op == OP_PROG_ADDR && !order_ok) |=>
        (rsp_valid_r && rsp_r.err && state_r == ST_IDLE && pins_r.ce_n))
        else $error("out of order program not refused");
    busy_hold_a: assert property (
        (state_r == ST_BUSY && cnt_r <= 1 && !rb_s) |=> state_r == ST_BUSY)
        else $error("busy wait ended while busy");
    one_strobe_a: assert property (!(!pins_r.we_n && !pins_r.re_n))
        else $error("both strobes low");
endmodule : nand_host

// ==== tb/nand_dev_model.sv ====
// Purpose: behavioural stacked-die flash answering the host pins
// Assumes: pins sampled on the host clock; reset stands for power-up
// Notes: a released bus shows the inverse of the last byte driven
`timescale 1ns/1ps
module nand_dev_model
    import nand_host_pkg::*;
#(
    parameter int BUSY = 3000                   // die operation length, cycles
) (
    input  wire logic  clock,
    input  wire logic  resetn,
    input  wire pins_s pins,
    output logic       rb,
    output logic [7:0] io_in,
    output int         errs
);
    int         busy_r [4];                     // per-die busy count
    int         init_r, idle_r, wake_r, acnt_r; // init, select idle, wake, address count
    logic       we_q, re_q, stat_r;             // strobe history, status mode
    die_t       die_r, sdie_r;                  // addressed die, queried die
    logic [7:0] ptr_r, last_r, sbyte;
    // ready only when no die and no init is busy
    assign rb = init_r == 0 && busy_r[0] == 0 && busy_r[1] == 0 && busy_r[2] == 0
        && busy_r[3] == 0;
    assign sbyte = {pins.wp_n, busy_r[sdie_r] == 0, 6'h00};
    // page zero cache pattern, loaded with no command
    assign io_in = (!pins.ce_n && !pins.re_n) ? (stat_r ? sbyte : ptr_r ^ 8'h5a)
        : ~last_r;
    // all device state in one process
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            init_r <= INIT_CYC; idle_r <= 0; wake_r <= 0; acnt_r <= 0; errs <= 0;
            we_q <= 1'b1; re_q <= 1'b1; stat_r <= 1'b0; die_r <= '0; sdie_r <= '0;
            ptr_r <= '0; last_r <= '0;
            foreach (busy_r[i]) busy_r[i] <= 0;
        end else begin
            we_q <= pins.we_n;
            re_q <= pins.re_n;
            foreach (busy_r[i]) if (busy_r[i] > 0) busy_r[i] <= busy_r[i] - 1;
            if (init_r > 0) init_r <= init_r - 1;
            if (init_r > 0 && pins.wp_n) errs <= errs + 1;
            idle_r <= pins.ce_n ? idle_r + 1 : 0;
            // select falls after a long idle: wake guard starts
            if (!pins.ce_n && idle_r >= SLEEP_CYC) wake_r <= WAKE_CYC;
            else if (wake_r > 0) wake_r <= wake_r - 1;
            if (((!pins.we_n && we_q) || (!pins.re_n && re_q)) && wake_r > 0)
                errs <= errs + 1;
            if (pins.we_n && !we_q && !pins.ce_n) begin
                if (pins.cle) begin
                    acnt_r <= 0;
                    // status opcodes run upward from the base, one per die
                    stat_r <= 8'(pins.io_out - CMD_STATUS_BASE) < 8'(DIES);
                    sdie_r <= die_t'(pins.io_out - CMD_STATUS_BASE);
                    if (pins.io_out == 8'h10 || pins.io_out == 8'hd0)
                        busy_r[die_r] <= BUSY;
                end else if (pins.ale) begin
                    acnt_r <= acnt_r + 1;
                    if (acnt_r == 4) die_r <= pins.io_out[1:0];
                end
            end
            if (pins.re_n && !re_q && !stat_r) ptr_r <= ptr_r + 8'h01;
            if (!pins.ce_n && !pins.re_n) last_r <= io_in;
        end
    end
endmodule : nand_dev_model

// ==== tb/nand_host_tb.sv ====
// Purpose: self-checking bench for the nand host controller
// Assumes: device model answers on the host clock
// Notes: order expectations come from a per-die integer model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module nand_host_tb;
    import nand_host_pkg::*;
    logic       clock = 1'b0, resetn = 1'b0, req_valid = 1'b0;
    req_s       req = '0;
    logic       req_ready, rsp_valid, init_done, rb;
    rsp_s       rsp;
    pins_s      pins;
    logic [7:0] io_in;
    int         failures = 0, checked = 0, errs, blk;
    int         last_blk [4], last_pg [4];      // bench order model
    int         pgs [6] = '{1, 3, 2, 0, 2, 3};  // pages tried in one block
    logic [31:0] seed = 32'd69485;
    always #5 clock = ~clock;
    nand_host DUT (.clock(clock), .resetn(resetn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done),
        .pins(pins), .rb(rb), .io_in(io_in));
    nand_dev_model model (.clock(clock), .resetn(resetn), .pins(pins), .rb(rb),
        .io_in(io_in), .errs(errs));
    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // random address inside one die
    function automatic addr_t in_die(input int d);
        return addr_t'(rnd() & 32'h07ffffff) | (addr_t'(d) << 27);
    endfunction : in_die
    task automatic end_sim();
        $display("counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // one request: held until taken, answer caught at a settled negedge
    task automatic xfer(input op_e o, input addr_t a, input logic [7:0] d);
        req_valid <= 1'b1;
        req <= '{op: o, addr: a, data: d};
        @(negedge clock);
        while (req_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        while (rsp_valid !== 1'b1) @(negedge clock);
        @(posedge clock);
    endtask : xfer
    task automatic status(input addr_t a, input logic [7:0] e);
        xfer(OP_DIE_STATUS, a, 8'h00);
        `CHK("status byte", e, rsp.data)
        `CHK("ready bit", e[6], rsp.ready_bit)
    endtask : status
    // refusal predicted from last page per die
    task automatic prog(input int d, input int b, input int pg);
        logic e;
        e = !((b == last_blk[d] && pg == last_pg[d] + 1) || (b != last_blk[d] && pg == 0));
        if (!e) begin
            last_blk[d] = b;
            last_pg[d] = pg;
        end
        xfer(OP_PROG_ADDR, (addr_t'(d) << 27) | (addr_t'(b) << 17) | (addr_t'(pg) << 11),
            8'h00);
        `CHK("order refusal", e, rsp.err)
    endtask : prog
    // main sequence
    initial begin
        foreach (last_blk[i]) begin
            last_blk[i] = -1;
            last_pg[i] = -1;
        end
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        `CHK("guard in reset", 1'b0, pins.wp_n)
        repeat (INIT_CYC - 10) @(posedge clock);
        `CHK("early init done", 1'b0, init_done)
        while (init_done !== 1'b1) @(negedge clock);
        `CHK("guard after init", 1'b1, pins.wp_n)
        $display("test init finished");
        @(posedge clock);
        xfer(OP_RD, '0, 8'h00);
        `CHK("page zero byte0", 8'h5a, rsp.data)
        xfer(OP_RD, '0, 8'h00);
        `CHK("page zero byte1", 8'h5b, rsp.data)
        $display("test page zero finished");
        // erase on die one, others stay ready
        xfer(OP_CMD, '0, 8'h60);
        xfer(OP_ADDR, in_die(1), 8'h00);
        xfer(OP_CMD, '0, 8'hd0);
        status(29'h07ffffff, 8'hc0);
        status(29'h08000000, 8'h80);
        status(29'h0fffffff, 8'h80);
        status(29'h10000000, 8'hc0);
        // program on die two while die one is busy
        blk = int'(rnd() % 1024);
        xfer(OP_CMD, '0, 8'h80);
        prog(2, blk, 0);
        xfer(OP_WR, '0, 8'(rnd()));
        xfer(OP_CMD, '0, 8'h10);
        status(29'h17ffffff, 8'h80);
        status(29'h18000000, 8'hc0);
        status(in_die(1), 8'h80);
        xfer(OP_WAIT_READY, '0, 8'h00);
        `CHK("wait ready bit", 1'b1, rsp.ready_bit)
        status(in_die(1), 8'hc0);
        status(in_die(2), 8'hc0);
        $display("test concurrent dies finished");
        foreach (pgs[i]) prog(2, blk, pgs[i]);
        prog(3, blk, 1);
        prog(3, blk, 0);
        prog(0, blk + 1, 0);
        $display("test page order finished");
        repeat (SLEEP_CYC + 200) @(posedge clock);
        status(in_die(3), 8'hc0);
        `CHK("device model faults", 0, errs)
        $display("test sleep wake finished");
        end_sim();
    end
    // hang guard, well past the expected run
    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        $display("wrong value watchdog expected finish seen hang");
        end_sim();
    end
endmodule : nand_host_tb
